// ===== rtl/two_wire_slave_regs.vh
// register map, field positions and reset values of the two-wire bus slave
// Behaviour
// - first byte after start is seven address bits then direction, zero meaning write.
// - matching address gets an acknowledge driven low during the ninth clock.
// - foreign address: data released, no interrupt, clock never held.
// - ninth falling clock after match raises address event and holds clock low.
// - receiving with wait timing select zero waits after the eighth clock.
// - clock stays low until software writes the wait release bit.
// - eighth falling clock of received byte holds clock and raises transfer end.
// - after release the slave drives acknowledge on the ninth clock.
// - data rising while clock high is a stop: flag set, interrupt raised.
// - transmit byte is loaded by software, shifted out after wait release.
// - transmitting, ack sampled on ninth rise; ninth fall holds clock, interrupts.
`ifndef TWO_WIRE_SLAVE_REGS_VH
`define TWO_WIRE_SLAVE_REGS_VH

// ****************************************************
// register byte offsets
// ****************************************************
`define OFF_CONTROL 5'h00
`define OFF_OWN_ADDRESS 5'h04
`define OFF_DATA 5'h08
`define OFF_STATUS 5'h0c
`define OFF_MASK 5'h10

// ****************************************************
// control register fields
// ****************************************************
`define CTL_ENABLE 0
`define CTL_WAIT_TIMING 1
`define CTL_WAIT_RELEASE 2

// ****************************************************
// status and mask fields (bits 0 to 3 sticky)
// ****************************************************
`define ST_ADDR_MATCH 0
`define ST_XFER_END 1
`define ST_STOP 2
`define ST_START 3
`define ST_TX_MODE 4
`define ST_ACK_DET 5
`define ST_WAITING 6
`define ST_BUSY 7

// ****************************************************
// reset values and counts
// ****************************************************
`define OWN_ADDRESS_RESET 7'h00
`define MASK_RESET 4'h0
`define BITS_PER_BYTE 4'h8
`define LAST_TX_BIT 4'h7

`endif

// ===== rtl/pin_sampler.v
// two-flop synchronisers and one history stage for the bus pins
module pin_sampler (
	// clock and reset
	input wire core_clk,
	input wire reset,
	// raw pins
	input wire scl_pin,
	input wire sda_pin,
	// synchronised levels and their previous values
	output reg scl_now,
	output reg sda_now,
	output reg scl_prev,
	output reg sda_prev
);

	reg scl_meta;
	reg sda_meta;

	// meta stage feeds only the second stage; idle bus reads high
	always @(posedge core_clk) begin
		if (reset) begin
			scl_meta <= 1'b1;
			sda_meta <= 1'b1;
			scl_now <= 1'b1;
			sda_now <= 1'b1;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_meta <= scl_pin;
			sda_meta <= sda_pin;
			scl_now <= scl_meta;
			sda_now <= sda_meta;
			scl_prev <= scl_now;
			sda_prev <= sda_now;
		end
	end

endmodule

// ===== rtl/two_wire_bus_slave_with_wait.v
// two-wire bus slave with clock stretching wait and avalon-mm registers
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`include "two_wire_slave_regs.vh"

module two_wire_bus_slave_with_wait (
	// clock and reset
	input wire core_clk,
	input wire reset,
	// avalon-mm register port
	input wire [4:0] address,
	input wire read,
	input wire write,
	input wire [3:0] byteenable,
	input wire [31:0] writedata,
	output reg [31:0] readdata,
	output reg waitrequest,
	// interrupt
	output reg irq,
	// bus clock pin, open drain
	input wire bus_clock_pin_in,
	output reg bus_clock_pin_out,
	output reg bus_clock_pin_oe,
	// bus data pin, open drain
	input wire bus_data_pin_in,
	output reg bus_data_pin_out,
	output reg bus_data_pin_oe
);

	// ****************************************************
	// state encoding
	// ****************************************************
	localparam S_IDLE = 8'h01;
	localparam S_ADDR = 8'h02;
	localparam S_AACK = 8'h04;
	localparam S_RX = 8'h08;
	localparam S_RACK = 8'h10;
	localparam S_TX = 8'h20;
	localparam S_TACK = 8'h40;
	localparam S_WAIT = 8'h80;

	// ****************************************************
	// declarations
	// ****************************************************
	reg enable, wait_timing_select, transmit_mode, ack_detected_flag;
	reg [6:0] own_address;
	reg [7:0] shift_data_register, rx_byte, rx_shift, tx_shift;
	reg [7:0] state, resume_state;
	reg [3:0] bit_count, status, mask;
	reg ev_addr, ev_xfer, ev_stop, ev_start;
	reg [31:0] next_readdata;
	wire scl_now, sda_now, scl_prev, sda_prev;
	wire scl_rise, scl_fall, start_cond, stop_cond;
	wire wr_take, rd_take, wait_release_bit, status_clear;

	// true when the byte address selects the given register
	function reg_hit;
		input [4:0] addr;
		input [4:0] offset;
		begin
			reg_hit = (addr == offset);
		end
	endfunction

	// ****************************************************
	// pin sampling and bus condition detection
	// ****************************************************
	pin_sampler u_pins (
		.core_clk(core_clk),
		.reset(reset),
		.scl_pin(bus_clock_pin_in),
		.sda_pin(bus_data_pin_in),
		.scl_now(scl_now),
		.sda_now(sda_now),
		.scl_prev(scl_prev),
		.sda_prev(sda_prev)
	);

	// edges of the synchronised lines; start and stop need clock high twice
	assign scl_rise = scl_now & ~scl_prev;
	assign scl_fall = ~scl_now & scl_prev;
	assign start_cond = scl_now & scl_prev & sda_prev & ~sda_now;
	assign stop_cond = scl_now & scl_prev & ~sda_prev & sda_now;

	// ****************************************************
	// avalon-mm slave
	// ****************************************************
	// an access completes in the cycle where waitrequest is low
	assign wr_take = write & ~waitrequest;
	assign rd_take = read & ~waitrequest;
	assign wait_release_bit = wr_take & byteenable[0] &
		reg_hit(address, `OFF_CONTROL) & writedata[`CTL_WAIT_RELEASE];
	assign status_clear = rd_take & reg_hit(address, `OFF_STATUS);

	// one wait cycle per access, so readdata is registered beforehand
	always @(posedge core_clk) begin
		if (reset) begin
			waitrequest <= 1'b1;
		end else if ((read | write) & waitrequest) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// read mux; unmapped offsets read as zero
	always @* begin
		next_readdata = 32'h0000_0000;
		if (reg_hit(address, `OFF_CONTROL)) begin
			next_readdata[`CTL_ENABLE] = enable;
			next_readdata[`CTL_WAIT_TIMING] = wait_timing_select;
		end else if (reg_hit(address, `OFF_OWN_ADDRESS)) begin
			next_readdata[6:0] = own_address;
		end else if (reg_hit(address, `OFF_DATA)) begin
			next_readdata[7:0] = rx_byte;
		end else if (reg_hit(address, `OFF_STATUS)) begin
			next_readdata[3:0] = status;
			next_readdata[`ST_TX_MODE] = transmit_mode;
			next_readdata[`ST_ACK_DET] = ack_detected_flag;
			next_readdata[`ST_WAITING] = (state == S_WAIT);
			next_readdata[`ST_BUSY] = (state != S_IDLE);
		end else if (reg_hit(address, `OFF_MASK)) begin
			next_readdata[3:0] = mask;
		end
	end

	// capture read data while the request waits
	always @(posedge core_clk) begin
		if (reset) begin
			readdata <= 32'h0000_0000;
		end else if (read & waitrequest) begin
			readdata <= next_readdata;
		end
	end

	// software written registers; only byte lane 0 carries fields
	always @(posedge core_clk) begin
		if (reset) begin
			enable <= 1'b0;
			wait_timing_select <= 1'b0;
			own_address <= `OWN_ADDRESS_RESET;
			shift_data_register <= 8'h00;
			mask <= `MASK_RESET;
		end else if (wr_take & byteenable[0]) begin
			if (reg_hit(address, `OFF_CONTROL)) begin
				enable <= writedata[`CTL_ENABLE];
				wait_timing_select <= writedata[`CTL_WAIT_TIMING];
			end
			if (reg_hit(address, `OFF_OWN_ADDRESS)) begin
				own_address <= writedata[6:0];
			end
			if (reg_hit(address, `OFF_DATA)) begin
				shift_data_register <= writedata[7:0];
			end
			if (reg_hit(address, `OFF_MASK)) begin
				mask <= writedata[3:0];
			end
		end
	end

	// ****************************************************
	// events and interrupt
	// ****************************************************
	// a status read clears only the bits it reported, so an event that
	// lands between capture and completion is not lost; set wins
	always @(posedge core_clk) begin
		if (reset) begin
			status <= 4'h0;
		end else begin
			status <= (status & ~({4{status_clear}} & readdata[3:0])) |
				{ev_start, ev_stop, ev_xfer, ev_addr};
		end
	end

	// single level interrupt for all events; open drain pins only pull low
	always @(posedge core_clk) begin
		bus_clock_pin_out <= 1'b0;
		bus_data_pin_out <= 1'b0;
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

	// ****************************************************
	// bus protocol engine
	// ****************************************************
	// start and stop override every state, so a restart always resyncs
	always @(posedge core_clk) begin
		if (reset) begin
			state <= S_IDLE;
			resume_state <= S_IDLE;
			bit_count <= 4'h0;
			rx_shift <= 8'h00;
			tx_shift <= 8'h00;
			rx_byte <= 8'h00;
			transmit_mode <= 1'b0;
			ack_detected_flag <= 1'b0;
			bus_clock_pin_oe <= 1'b0;
			bus_data_pin_oe <= 1'b0;
			ev_addr <= 1'b0;
			ev_xfer <= 1'b0;
			ev_stop <= 1'b0;
			ev_start <= 1'b0;
		end else begin
			ev_addr <= 1'b0;
			ev_xfer <= 1'b0;
			ev_stop <= 1'b0;
			ev_start <= 1'b0;
			if (!enable) begin
				state <= S_IDLE;
				bus_clock_pin_oe <= 1'b0;
				bus_data_pin_oe <= 1'b0;
			end else if (stop_cond) begin
				state <= S_IDLE;
				bus_clock_pin_oe <= 1'b0;
				bus_data_pin_oe <= 1'b0;
				ev_stop <= 1'b1;
			end else if (start_cond) begin
				state <= S_ADDR;
				bit_count <= 4'h0;
				bus_clock_pin_oe <= 1'b0;
				bus_data_pin_oe <= 1'b0;
				ev_start <= 1'b1;
			end else begin
				case (state)
				S_ADDR: begin
					// seven address bits, then direction
					if (scl_rise) begin
						rx_shift <= {rx_shift[6:0], sda_now};
						bit_count <= bit_count + 4'h1;
					end else if (scl_fall &&
						bit_count == `BITS_PER_BYTE) begin
						if (rx_shift[7:1] == own_address) begin
							bus_data_pin_oe <= 1'b1;
							transmit_mode <= rx_shift[0];
							state <= S_AACK;
						end else begin
							// stay silent and never stretch
							state <= S_IDLE;
						end
					end
				end
				S_AACK: begin
					if (scl_fall) begin
						bus_data_pin_oe <= 1'b0;
						bus_clock_pin_oe <= 1'b1;
						ev_addr <= 1'b1;
						bit_count <= 4'h0;
						resume_state <= transmit_mode ? S_TX : S_RX;
						state <= S_WAIT;
					end
				end
				S_RX: begin
					if (scl_rise) begin
						rx_shift <= {rx_shift[6:0], sda_now};
						bit_count <= bit_count + 4'h1;
					end else if (scl_fall &&
						bit_count == `BITS_PER_BYTE) begin
						rx_byte <= rx_shift;
						if (!wait_timing_select) begin
							bus_clock_pin_oe <= 1'b1;
							ev_xfer <= 1'b1;
							resume_state <= S_RACK;
							state <= S_WAIT;
						end else begin
							// nine-clock wait: ack first
							bus_data_pin_oe <= 1'b1;
							state <= S_RACK;
						end
					end
				end
				S_RACK: begin
					if (scl_fall) begin
						bus_data_pin_oe <= 1'b0;
						bit_count <= 4'h0;
						if (wait_timing_select) begin
							bus_clock_pin_oe <= 1'b1;
							ev_xfer <= 1'b1;
							resume_state <= S_RX;
							state <= S_WAIT;
						end else begin
							state <= S_RX;
						end
					end
				end
				S_TX: begin
					// next bit goes out while the clock is low
					if (scl_fall) begin
						if (bit_count == `LAST_TX_BIT) begin
							bus_data_pin_oe <= 1'b0;
							state <= S_TACK;
						end else begin
							tx_shift <= {tx_shift[6:0], 1'b0};
							bus_data_pin_oe <= ~tx_shift[6];
							bit_count <= bit_count + 4'h1;
						end
					end
				end
				S_TACK: begin
					if (scl_rise) begin
						ack_detected_flag <= ~sda_now;
					end else if (scl_fall) begin
						bus_clock_pin_oe <= 1'b1;
						ev_xfer <= 1'b1;
						// a refused byte ends our part of it
						resume_state <= ack_detected_flag ?
							S_TX : S_IDLE;
						state <= S_WAIT;
					end
				end
				S_WAIT: begin
					// master edges are ignored while we stretch
					bus_clock_pin_oe <= 1'b1;
					if (wait_release_bit) begin
						bus_clock_pin_oe <= 1'b0;
						state <= resume_state;
						if (resume_state == S_RACK) begin
							bus_data_pin_oe <= 1'b1;
						end
						if (resume_state == S_TX) begin
							tx_shift <= shift_data_register;
							bus_data_pin_oe <=
								~shift_data_register[7];
							bit_count <= 4'h0;
							ack_detected_flag <= 1'b0;
						end
					end
				end
				default: begin
					state <= S_IDLE;
					bus_clock_pin_oe <= 1'b0;
					bus_data_pin_oe <= 1'b0;
				end
				endcase
			end
		end
	end

endmodule

// ===== tb/two_wire_master_model.sv
// behavioural bus master that clocks the two-wire link
module two_wire_master_model (
	// wire levels seen on the bus
	input logic scl,
	input logic sda,
	// open-drain pull-low enables
	output logic scl_oe,
	output logic sda_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	int stalls = 0;

	// lines released at power up; pull-ups give idle high
	initial begin
		scl_oe = 0;
		sda_oe = 0;
	end

	// ************************************************
	// bit, start, stop and byte cycles
	// ************************************************
	// low 239 ns, high 81 ns; a slave stretch lengthens the low, and the high by under 40 ns
	task automatic clk_bit(input logic b, output logic r);
		int n;
		#120 sda_oe = !b;
		#119 scl_oe = 0;
		#1 n = 0;
		while (!scl && n < 4000) begin
			#40 n++;
		end
		if (n == 4000) stalls++;
		r = sda;
		#80 scl_oe = 1;
	endtask

	// data falls while the clock is high, then clock is pulled low
	task automatic start_cond;
		sda_oe = 1;
		#160 scl_oe = 1;
	endtask

	// data rises while the clock is high
	task automatic stop_cond;
		#120 sda_oe = 1;
		#120 scl_oe = 0;
		#160 sda_oe = 0;
	endtask

	// eight bits msb first, then the ninth acknowledge clock
	task automatic xfer(input logic [7:0] d, input logic ack_in,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
		clk_bit(ack_in, ack);
	endtask
endmodule

// ===== tb/two_wire_slave_sva.sv
// concurrent checks on the ports of the two-wire bus slave
module two_wire_slave_sva (
	// clock and reset
	input wire core_clk,
	input wire reset,
	// register port
	input wire [4:0] address,
	input wire read,
	input wire write,
	input wire [3:0] byteenable,
	input wire [31:0] writedata,
	input wire [31:0] readdata,
	input wire waitrequest,
	// interrupt and pins
	input wire irq,
	input wire bus_clock_pin_in,
	input wire bus_clock_pin_out,
	input wire bus_clock_pin_oe,
	input wire bus_data_pin_in,
	input wire bus_data_pin_out,
	input wire bus_data_pin_oe
);
	reg [3:0] mask_seen;
	// an accepted write that sets the wait release bit
	wire rel = write && !waitrequest && address == 5'h00 && byteenable[0]
		&& writedata[2];

	// shadow of the mask so irq can be tied to what software enabled
	always @(posedge core_clk)
		if (reset) mask_seen <= 4'h0;
		else if (write && !waitrequest && address == 5'h10 && byteenable[0])
			mask_seen <= writedata[3:0];

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	chk_wait_bounded: assert property ((read || write) |-> ##[0:1] !waitrequest)
		else $error("register access not answered in time");
	chk_wait_single: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_idle_wait: assert property (!read && !write |-> waitrequest)
		else $error("waitrequest low with no request");
	chk_pin_levels: assert property (!bus_clock_pin_out && !bus_data_pin_out)
		else $error("open-drain output level not low");
	chk_stretch_keep: assert property (
		$fell(bus_clock_pin_oe) |-> $past(rel) || $past(rel, 2) || $past(rel, 3))
		else $error("clock hold dropped without a release");
	chk_stretch_low: assert property (
		$rose(bus_clock_pin_oe) |-> !$past(bus_clock_pin_in)
		&& !$past(bus_clock_pin_in, 2))
		else $error("clock hold began while clock high");
	chk_data_low_clk: assert property (
		$changed(bus_data_pin_oe) |-> !$past(bus_clock_pin_in)
		&& !$past(bus_clock_pin_in, 2))
		else $error("data pin moved while clock high");
	chk_irq_masked: assert property (
		irq |-> ($past(mask_seen) | $past(mask_seen, 2)) != 4'h0)
		else $error("irq raised with mask clear");

	cover property ($rose(bus_clock_pin_oe));
	cover property ($rose(irq));
	cover property ($fell(bus_data_pin_oe));
endmodule

bind two_wire_bus_slave_with_wait two_wire_slave_sva sva (.core_clk(core_clk),
	.reset(reset), .address(address), .read(read), .write(write),
	.byteenable(byteenable), .writedata(writedata), .readdata(readdata),
	.waitrequest(waitrequest), .irq(irq), .bus_clock_pin_in(bus_clock_pin_in),
	.bus_clock_pin_out(bus_clock_pin_out), .bus_clock_pin_oe(bus_clock_pin_oe),
	.bus_data_pin_in(bus_data_pin_in), .bus_data_pin_out(bus_data_pin_out),
	.bus_data_pin_oe(bus_data_pin_oe));

// ===== tb/test_two_wire_bus_slave_with_wait.sv
// self-checking bench for the two-wire bus slave
module test_two_wire_bus_slave_with_wait;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, reset = 1, read = 0, write = 0;
	logic [4:0] address = '0;
	logic [3:0] byteenable = 4'hf;
	logic [31:0] writedata = '0, rd;
	wire [31:0] readdata;
	wire waitrequest, irq, clk_oe, dat_oe;
	wire logic m_scl_oe, m_sda_oe;
	// wired-and bus with pull-ups
	wire logic scl = !(clk_oe || m_scl_oe);
	wire logic sda = !(dat_oe || m_sda_oe);
	int num_errors = 0, num_checks = 0;
	logic [7:0] q;
	logic a;

	always #20 core_clk = !core_clk;

	two_wire_bus_slave_with_wait DUT (.core_clk(core_clk), .reset(reset),
		.address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .irq(irq),
		.bus_clock_pin_in(scl), .bus_clock_pin_out(),
		.bus_clock_pin_oe(clk_oe), .bus_data_pin_in(sda),
		.bus_data_pin_out(), .bus_data_pin_oe(dat_oe));
	two_wire_master_model master (.scl(scl), .sda(sda),
		.scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

	// ************************************************
	// compare, verdict and register access
	// ************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		num_errors += master.stalls;
		if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// request held until waitrequest is sampled low
	task automatic access(input logic w, input logic [4:0] ad,
		input logic [31:0] d);
		int n;
		@(posedge core_clk);
		read <= !w;
		write <= w;
		address <= ad;
		writedata <= d;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 100);
		if (n == 100) num_errors++;
		if (n == 100) print_verdict();
		rd = readdata;
		read <= 0;
		write <= 0;
	endtask

	task automatic rchk(input logic [4:0] ad, input logic [31:0] m, e);
		access(0, ad, '0);
		check(rd & m, e);
	endtask

	// bounded wait so a missing event cannot hang the run
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 5000) begin
			@(posedge core_clk);
			n++;
		end
		if (n == 5000) num_errors++;
		if (n == 5000) print_verdict();
	endtask

	// ************************************************
	// byte level transfers with software servicing
	// ************************************************
	task automatic rx_byte(input logic [7:0] d);
		fork
			master.xfer(d, 1, q, a);
			begin
				wait_irq();
				rchk(5'h08, 32'h0000_00ff, 32'(d));
				rchk(5'h0c, 32'h0000_0017, 32'h0000_0002);
				check(clk_oe, 1);
				access(1, 5'h00, 32'h0000_0005);
			end
		join
		check(a, 0);
	endtask

	task automatic tx_byte(input logic [7:0] d, input logic nack);
		access(1, 5'h08, 32'(d));
		access(1, 5'h00, 32'h0000_0005);
		fork
			master.xfer(8'hff, nack, q, a);
			begin
				wait_irq();
				rchk(5'h0c, 32'h0000_0023,
					nack ? 32'h0000_0002 : 32'h0000_0022);
			end
		join
		check(32'(q), 32'(d));
	endtask

	task automatic stop_seen;
		master.stop_cond();
		wait_irq();
		rchk(5'h0c, 32'h0000_0007, 32'h0000_0004);
	endtask

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		repeat (4) @(posedge core_clk);
		reset <= 0;
		rchk(5'h00, 32'hffff_ffff, 32'h0000_0000);
		rchk(5'h0c, 32'hffff_ffff, 32'h0000_0000);
		rchk(5'h10, 32'hffff_ffff, 32'h0000_0000);
		access(1, 5'h14, 32'h0000_00ff);
		rchk(5'h14, 32'hffff_ffff, 32'h0000_0000);
		access(1, 5'h04, 32'h0000_002a);
		rchk(5'h04, 32'h0000_007f, 32'h0000_002a);
		// a write without byte lane 0 leaves the register alone
		byteenable <= 4'he;
		access(1, 5'h04, 32'h0000_0011);
		byteenable <= 4'hf;
		rchk(5'h04, 32'h0000_007f, 32'h0000_002a);
		access(1, 5'h10, 32'h0000_0007);
		access(1, 5'h00, 32'h0000_0001);
		// foreign address: no ack, no hold, no interrupt
		master.start_cond();
		master.xfer(8'h2a, 1, q, a);
		check(a, 1);
		#400 check({irq, clk_oe}, 0);
		stop_seen();
		// write transfer, two bytes back to back
		master.start_cond();
		master.xfer(8'h54, 1, q, a);
		check(a, 0);
		wait_irq();
		rchk(5'h0c, 32'h0000_0017, 32'h0000_0001);
		check(clk_oe, 1);
		access(1, 5'h00, 32'h0000_0005);
		rx_byte(8'ha5);
		rx_byte(8'h3c);
		// nine-clock wait: ack at once, hold after the ninth clock
		access(1, 5'h00, 32'h0000_0003);
		master.xfer(8'h96, 1, q, a);
		check(a, 0);
		wait_irq();
		rchk(5'h08, 32'h0000_00ff, 32'h0000_0096);
		rchk(5'h0c, 32'h0000_0057, 32'h0000_0042);
		check(clk_oe, 1);
		access(1, 5'h00, 32'h0000_0007);
		stop_seen();
		// read transfer: one byte acked, the next refused
		master.start_cond();
		master.xfer(8'h55, 1, q, a);
		check(a, 0);
		wait_irq();
		rchk(5'h0c, 32'h0000_0017, 32'h0000_0011);
		tx_byte(8'hc3, 0);
		tx_byte(8'h5a, 1);
		access(1, 5'h00, 32'h0000_0005);
		stop_seen();
		// masked events set status but leave irq low
		access(1, 5'h10, 32'h0000_0000);
		master.start_cond();
		master.stop_cond();
		#400 check(irq, 0);
		rchk(5'h0c, 32'h0000_000f, 32'h0000_000c);
		print_verdict();
	end
endmodule
